// ### rtl/fim_pkg.sv
/*
 constants for the framer interrupt masking block: register offsets, bit
 positions of the two mask words, vector codes and interrupt status layout.
 assumes a byte-wide register port with 5-bit addresses.
*/
package fim_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [4:0] OFS_IRQ_EN_CNT_ALIGN = 5'h1d;
   localparam logic [4:0] OFS_IRQ_EN_SYNC_TMR = 5'h1e;
   localparam logic [4:0] OFS_TX_PULSE_CTRL = 5'h1f;
   localparam logic [4:0] OFS_IRQ_STATUS_A = 5'h10;
   localparam logic [4:0] OFS_IRQ_STATUS_B = 5'h11;
   localparam logic [4:0] OFS_IRQ_CLEAR_A = 5'h12;
   localparam logic [4:0] OFS_IRQ_CLEAR_B = 5'h13;
   localparam logic [4:0] OFS_IRQ_VECTOR = 5'h14;
   localparam logic [4:0] OFS_SRC_LEVELS = 5'h15;

   // mask word two bit positions
   localparam int BIT_EBIT_OVF = 7;
   localparam int BIT_LCRC_OVF = 6;
   localparam int BIT_CRC_ALIGN = 5;
   localparam int BIT_FAS_OVF = 4;
   localparam int BIT_JIT_MARGIN = 3;
   localparam int BIT_BITERR_OVF = 2;
   localparam int BIT_AUX_PAT = 1;
   localparam int BIT_CMF_OVF = 0;

   // mask word three bit positions
   localparam int BIT_SIG_MF_LOSS = 7;
   localparam int BIT_CRC_MF_LOSS = 6;
   localparam int BIT_REMOTE_MF = 4;
   localparam int BIT_ONE_SEC = 3;
   localparam int BIT_TIMER_ONE = 2;
   localparam int BIT_TIMER_TWO = 1;

   // writable bits of each word; others read zero
   localparam logic [7:0] MASK_WORD_TWO_USED = 8'hff;
   localparam logic [7:0] MASK_WORD_THREE_USED = 8'hde;
   localparam logic [7:0] TX_PULSE_USED = 8'h0f;
   localparam logic [7:0] RESET_ZERO = 8'h00;

   // vector codes
   localparam logic [7:0] VEC_SYNC_LOSS = 8'h80;
   localparam logic [7:0] VEC_PATTERN = 8'h40;
   localparam logic [7:0] VEC_COUNTER_OVF = 8'h10;
   localparam logic [7:0] VEC_STATUS_CHANGE = 8'h08;
   localparam logic [7:0] VEC_JITTER = 8'h04;
   localparam logic [7:0] VEC_NONE = 8'h00;

   // transmit pulse word fields
   localparam int BIT_CUSTOM_PULSE = 3;
   localparam int AMP_MSB = 2;

endpackage

// ### rtl/fim_edge_det.sv
/*
 rise or any-change detector for one status level.
 assumes the level is synchronous to clk.
*/
`timescale 1ns/1ps
module fim_edge_det
   #(parameter bit ANY_CHANGE = 1'b0)
   (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic level, // monitored flag
   output logic pulse // one-cycle event
   );

   logic prev;

   // previous level; starts low so a flag high out of reset counts as a rise
   always_ff @(posedge clk)
   begin
      if (rst)
         prev <= 1'b0;
      else
         prev <= level;
   end

   assign pulse = ANY_CHANGE ? (level ^ prev) : (level & ~prev);

endmodule

// ### rtl/fim_top.sv
/*
 interrupt masking for the framer: two enable words gate counter overflow,
 alignment, sync loss, alarm, timer and jitter fifo events into sticky status
 bits, one level interrupt and an 8-bit vector.
 status words are read-only and the clear words are write-one-to-clear. a
 stored bit stays until software clears it, even after its source goes idle.
 assumes event inputs are one-cycle pulses and status flags are levels, all
 synchronous to MCLK; register port with read data one cycle after the strobe.
 the jitter fill input counts bytes held in the fifo, zero meaning empty.
 the clear words have no storage, so they read back as zero.
 a read and a write never share a cycle on the register port.
*/
`timescale 1ns/1ps
module fim_top
   import fim_pkg::*;
   #(parameter int FIFO_DEPTH = 32, // jitter fifo depth in bytes
     parameter int FILL_W = 6, // width of fill level input
     parameter int MARGIN = 4) // bytes from either limit
   (
   input wire logic MCLK, // system clock 250 MHz
   input wire logic SYS_RST, // sync reset, active high
   input wire logic [ADDR_W-1:0] ADDR, // register address
   input wire logic [DATA_W-1:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [DATA_W-1:0] RDATA, // read data, cycle after RD
   input wire logic EBIT_CNT_OVF, // e-bit counter overflow pulse
   input wire logic LCRC_CNT_OVF, // local crc-4 counter overflow pulse
   input wire logic FAS_CNT_OVF, // fas error counter overflow pulse
   input wire logic BITERR_CNT_OVF, // bit error counter overflow pulse
   input wire logic CMF_CNT_OVF, // crc-4 multiframe counter overflow pulse
   input wire logic CRC_ALIGN_STATUS, // crc-4 alignment flag level
   input wire logic AUX_PATTERN_STATUS, // auxiliary pattern flag level
   input wire logic SIG_MF_SYNC_LOST, // signalling mf sync lost level
   input wire logic CRC_MF_SYNC_LOST, // crc-4 mf sync lost level
   input wire logic REMOTE_MF_ALARM, // remote mf alarm level
   input wire logic ONE_SECOND_FLAG, // one-second flag level
   input wire logic TIMER_ONE_FLAG, // first timer flag level
   input wire logic TIMER_TWO_FLAG, // second timer flag level
   input wire logic [FILL_W-1:0] JIT_FIFO_FILL, // jitter fifo fill in bytes
   output logic IRQ, // level interrupt
   output logic [DATA_W-1:0] IRQ_VECTOR, // vector of highest pending source
   output logic CUSTOM_PULSE_SELECT, // custom pulse level select
   output logic [2:0] PULSE_AMPLITUDE_CODE // transmit pulse amplitude code
   );

   // elaboration checks: both near-limit windows must fit inside the fifo with a
   // gap between them, and the fill input must be able to count the whole depth;
   // a zero margin would make the jitter source fire only at the very limits
   if (MARGIN < 1)
   begin : g_bad_margin_low
      $error("fim_top: margin must be at least one byte");
   end
   if (FIFO_DEPTH < 2 * MARGIN + 2)
   begin : g_bad_margin_high
      $error("fim_top: margin too wide for the fifo depth");
   end
   if (FIFO_DEPTH >= (1 << FILL_W))
   begin : g_bad_fill
      $error("fim_top: fill width too narrow for the fifo depth");
   end

   // registers
   logic [7:0] irq_enable_counters_alignment;
   logic [7:0] irq_enable_sync_timers;
   logic [7:0] transmit_pulse_level_control;
   logic [7:0] status_a;
   logic [7:0] status_b;
   logic [7:0] vector;
   logic [7:0] rdata;

   // level-to-event detection
   logic ev_align_chg;
   logic ev_aux_rise;
   logic ev_sig_loss;
   logic ev_crc_loss;
   logic ev_remote;
   logic ev_one_sec;
   logic ev_timer_one;
   logic ev_timer_two;
   logic ev_jitter;
   logic jit_near;

   // alignment reacts to either direction, the rest to rising only
   // the detectors start low, so a flag already high at reset release counts once
   fim_edge_det #(.ANY_CHANGE(1'b1)) u_align
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(CRC_ALIGN_STATUS),
      .pulse(ev_align_chg)
   );

   fim_edge_det u_aux
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(AUX_PATTERN_STATUS),
      .pulse(ev_aux_rise)
   );

   fim_edge_det u_sigloss
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(SIG_MF_SYNC_LOST),
      .pulse(ev_sig_loss)
   );

   fim_edge_det u_crcloss
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(CRC_MF_SYNC_LOST),
      .pulse(ev_crc_loss)
   );

   fim_edge_det u_remote
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(REMOTE_MF_ALARM),
      .pulse(ev_remote)
   );

   fim_edge_det u_onesec
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(ONE_SECOND_FLAG),
      .pulse(ev_one_sec)
   );

   fim_edge_det u_tmr1
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(TIMER_ONE_FLAG),
      .pulse(ev_timer_one)
   );

   fim_edge_det u_tmr2
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(TIMER_TWO_FLAG),
      .pulse(ev_timer_two)
   );

   // near-limit window; an event on entering it, not for every cycle inside
   // the window edges are inclusive: a fill of MARGIN or DEPTH-MARGIN is near
   assign jit_near = (JIT_FIFO_FILL <= FILL_W'(MARGIN))
                  || (JIT_FIFO_FILL >= FILL_W'(FIFO_DEPTH - MARGIN));

   fim_edge_det u_jit
   (
      .clk(MCLK),
      .rst(SYS_RST),
      .level(jit_near),
      .pulse(ev_jitter)
   );

   // events in status layout, word two then word three
   logic [7:0] raw_a;
   logic [7:0] raw_b;

   assign raw_a[BIT_EBIT_OVF] = EBIT_CNT_OVF;
   assign raw_a[BIT_LCRC_OVF] = LCRC_CNT_OVF;
   assign raw_a[BIT_CRC_ALIGN] = ev_align_chg;
   assign raw_a[BIT_FAS_OVF] = FAS_CNT_OVF;
   assign raw_a[BIT_JIT_MARGIN] = ev_jitter;
   assign raw_a[BIT_BITERR_OVF] = BITERR_CNT_OVF;
   assign raw_a[BIT_AUX_PAT] = ev_aux_rise;
   assign raw_a[BIT_CMF_OVF] = CMF_CNT_OVF;

   // word three layout; bits 5 and 0 have no source
   assign raw_b[BIT_SIG_MF_LOSS] = ev_sig_loss;
   assign raw_b[BIT_CRC_MF_LOSS] = ev_crc_loss;
   assign raw_b[5] = 1'b0;
   assign raw_b[BIT_REMOTE_MF] = ev_remote;
   assign raw_b[BIT_ONE_SEC] = ev_one_sec;
   assign raw_b[BIT_TIMER_ONE] = ev_timer_one;
   assign raw_b[BIT_TIMER_TWO] = ev_timer_two;
   assign raw_b[0] = 1'b0;

   // masked events: a masked source never reaches status
   // word three is masked again so an unused bit can never be stored
   wire [7:0] set_a = raw_a & irq_enable_counters_alignment;
   wire [7:0] set_b = raw_b & irq_enable_sync_timers & MASK_WORD_THREE_USED;

   // address decode
   wire wr_en_a = WR && (ADDR == OFS_IRQ_EN_CNT_ALIGN);
   wire wr_en_b = WR && (ADDR == OFS_IRQ_EN_SYNC_TMR);
   wire wr_tx = WR && (ADDR == OFS_TX_PULSE_CTRL);

   // clear words: a one clears the matching status bit, a zero leaves it
   wire wr_clr_a = WR && (ADDR == OFS_IRQ_CLEAR_A);
   wire wr_clr_b = WR && (ADDR == OFS_IRQ_CLEAR_B);
   wire [7:0] clr_a = wr_clr_a ? WDATA : RESET_ZERO;
   wire [7:0] clr_b = wr_clr_b ? WDATA : RESET_ZERO;

   // sticky status: a new event wins over a clear in the same cycle
   wire [7:0] next_status_a = (status_a & ~clr_a) | set_a;
   wire [7:0] next_status_b = (status_b & ~clr_b) | set_b;

   // enable word two; every bit is a live enable
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         irq_enable_counters_alignment <= RESET_ZERO;
      else if (wr_en_a)
         irq_enable_counters_alignment <= WDATA & MASK_WORD_TWO_USED;
   end

   // enable word three; unused bits are dropped on write so they read zero
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         irq_enable_sync_timers <= RESET_ZERO;
      else if (wr_en_b)
         irq_enable_sync_timers <= WDATA & MASK_WORD_THREE_USED;
   end

   // transmit pulse word; only the select bit and amplitude code are kept
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         transmit_pulse_level_control <= RESET_ZERO;
      else if (wr_tx)
         transmit_pulse_level_control <= WDATA & TX_PULSE_USED;
   end

   // status word two; set beats clear inside next_status_a
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         status_a <= RESET_ZERO;
      else
         status_a <= next_status_a;
   end

   // status word three; same rule as word two
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         status_b <= RESET_ZERO;
      else
         status_b <= next_status_b;
   end

   // enabled pending bits; disabling a source also hides its stale status
   // re-enabling it shows the stale bit again unless software clears it first
   wire [7:0] pend_a = status_a & irq_enable_counters_alignment;
   wire [7:0] pend_b = status_b & irq_enable_sync_timers;

   // vector priority follows the code weight, highest first
   wire pend_sync = pend_b[BIT_SIG_MF_LOSS] | pend_b[BIT_CRC_MF_LOSS] | pend_b[BIT_REMOTE_MF];
   wire pend_pat = pend_a[BIT_AUX_PAT];

   // counter overflows share one class
   wire pend_ovf = pend_a[BIT_EBIT_OVF] | pend_a[BIT_LCRC_OVF] | pend_a[BIT_FAS_OVF]
                 | pend_a[BIT_BITERR_OVF] | pend_a[BIT_CMF_OVF];

   // status changes and timer ticks share one class
   wire pend_chg = pend_a[BIT_CRC_ALIGN] | pend_b[BIT_ONE_SEC]
                 | pend_b[BIT_TIMER_ONE] | pend_b[BIT_TIMER_TWO];

   // jitter margin is lowest; the fifo still has four bytes of slack
   wire pend_jit = pend_a[BIT_JIT_MARGIN];

   // the vector names the class only; software reads status to find the source
   wire [7:0] next_vector = pend_sync ? VEC_SYNC_LOSS :
                            pend_pat ? VEC_PATTERN :
                            pend_ovf ? VEC_COUNTER_OVF :
                            pend_chg ? VEC_STATUS_CHANGE :
                            pend_jit ? VEC_JITTER : VEC_NONE;

   // registered so the vector and IRQ never glitch between classes
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         vector <= VEC_NONE;
      else
         vector <= next_vector;
   end

   // read address decode; the read strobe qualifies every select
   wire rd_sel_en_a = RD && (ADDR == OFS_IRQ_EN_CNT_ALIGN);
   wire rd_sel_en_b = RD && (ADDR == OFS_IRQ_EN_SYNC_TMR);
   wire rd_sel_tx = RD && (ADDR == OFS_TX_PULSE_CTRL);
   wire rd_sel_st_a = RD && (ADDR == OFS_IRQ_STATUS_A);
   wire rd_sel_st_b = RD && (ADDR == OFS_IRQ_STATUS_B);
   wire rd_sel_vec = RD && (ADDR == OFS_IRQ_VECTOR);
   wire rd_sel_lvl = RD && (ADDR == OFS_SRC_LEVELS);

   // live source levels, for polling without an interrupt
   wire [7:0] src_levels = {CRC_ALIGN_STATUS, AUX_PATTERN_STATUS, jit_near,
                            ONE_SECOND_FLAG, TIMER_ONE_FLAG, TIMER_TWO_FLAG, 2'b00};

   // and-or read mux; unmapped addresses and idle cycles read zero
   wire [7:0] next_rdata = ({8{rd_sel_en_a}} & irq_enable_counters_alignment)
                         | ({8{rd_sel_en_b}} & irq_enable_sync_timers)
                         | ({8{rd_sel_tx}} & transmit_pulse_level_control)
                         | ({8{rd_sel_st_a}} & status_a)
                         | ({8{rd_sel_st_b}} & status_b)
                         | ({8{rd_sel_vec}} & vector)
                         | ({8{rd_sel_lvl}} & src_levels);

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge MCLK)
   begin
      if (SYS_RST)
         rdata <= RESET_ZERO;
      else
         rdata <= next_rdata;
   end

   // register read port
   assign RDATA = rdata;

   // interrupt outputs; IRQ follows the registered vector, so both move together
   assign IRQ_VECTOR = vector;
   assign IRQ = |vector;

   // transmit pulse fields straight from their register
   assign CUSTOM_PULSE_SELECT = transmit_pulse_level_control[BIT_CUSTOM_PULSE];
   assign PULSE_AMPLITUDE_CODE = transmit_pulse_level_control[AMP_MSB:0];

endmodule

// ### tb/fim_top_properties.sv
/*
 checker for fim_top: reset, register port, event to interrupt timing.
 assumes it is bound to fim_top and sees only its ports.
*/
`timescale 1ns/1ps
module fim_top_properties
   import fim_pkg::*;
   (
   input wire logic MCLK, // clock
   input wire logic SYS_RST, // sync reset
   input wire logic [ADDR_W-1:0] ADDR, // address
   input wire logic [DATA_W-1:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   input wire logic [DATA_W-1:0] RDATA, // read data
   input wire logic EBIT_CNT_OVF, // overflow pulse
   input wire logic AUX_PATTERN_STATUS, // pattern level
   input wire logic SIG_MF_SYNC_LOST, // sync loss level
   input wire logic IRQ, // interrupt
   input wire logic [DATA_W-1:0] IRQ_VECTOR, // vector
   input wire logic CUSTOM_PULSE_SELECT, // pulse select
   input wire logic [2:0] PULSE_AMPLITUDE_CODE // amplitude
   );
   logic [7:0] en2;
   logic [7:0] en3;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // shadow enables, so event checks know which sources are open
   always_ff @(posedge MCLK)
      en2 <= SYS_RST ? 8'h00 : (WR && ADDR == OFS_IRQ_EN_CNT_ALIGN) ? WDATA : en2;
   always_ff @(posedge MCLK)
      en3 <= SYS_RST ? 8'h00 : (WR && ADDR == OFS_IRQ_EN_SYNC_TMR) ? WDATA & MASK_WORD_THREE_USED : en3;
   // event sequences
   sequence s_tx_wr;
      WR && ADDR == OFS_TX_PULSE_CTRL;
   endsequence
   sequence s_sync_rise;
      en3[7] && $rose(SIG_MF_SYNC_LOST);
   endsequence
   sequence s_aux_rise;
      en2[1] && $rose(AUX_PATTERN_STATUS);
   endsequence
   property p_rst;
      disable iff (1'b0) SYS_RST |=> !IRQ && IRQ_VECTOR == 8'h00 && RDATA == 8'h00;
   endproperty
   property p_idle;
      !RD |=> RDATA == 8'h00;
   endproperty
   property p_masked;
      en2 == 8'h00 && en3 == 8'h00 |=> !IRQ;
   endproperty
   property p_ebit;
      en2[7] && EBIT_CNT_OVF |-> ##2 IRQ;
   endproperty
   property p_sync;
      s_sync_rise |-> ##2 IRQ_VECTOR == VEC_SYNC_LOSS;
   endproperty
   property p_aux;
      s_aux_rise |-> ##2 IRQ_VECTOR == VEC_PATTERN || IRQ_VECTOR == VEC_SYNC_LOSS;
   endproperty
   property p_tx;
      s_tx_wr |=> {4'h0, CUSTOM_PULSE_SELECT, PULSE_AMPLITUDE_CODE} == ($past(WDATA) & TX_PULSE_USED);
   endproperty
   property p_rdback;
      RD && ADDR == OFS_IRQ_EN_SYNC_TMR |=> RDATA == en3;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   a_idle: assert property (p_idle) else $error("read data outside read slot");
   a_masked: assert property (p_masked) else $error("interrupt with all masked");
   a_ebit: assert property (p_ebit) else $error("overflow did not interrupt");
   a_sync: assert property (p_sync) else $error("sync loss vector wrong");
   a_aux: assert property (p_aux) else $error("pattern vector missing");
   a_tx: assert property (p_tx) else $error("pulse outputs wrong");
   a_rdback: assert property (p_rdback) else $error("word three readback wrong");
endmodule

bind fim_top fim_top_properties u_fim_top_properties (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EBIT_CNT_OVF(EBIT_CNT_OVF),
   .AUX_PATTERN_STATUS(AUX_PATTERN_STATUS), .SIG_MF_SYNC_LOST(SIG_MF_SYNC_LOST), .IRQ(IRQ),
   .IRQ_VECTOR(IRQ_VECTOR), .CUSTOM_PULSE_SELECT(CUSTOM_PULSE_SELECT),
   .PULSE_AMPLITUDE_CODE(PULSE_AMPLITUDE_CODE));

// ### tb/fim_top_tb.sv
/*
 bench for fim_top: reset values, registers, every event source, masking.
 assumes the checker is bound separately; inputs change at rising edges.
*/
`timescale 1ns/1ps
module fim_top_tb;
   import fim_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic [4:0] ovf = 5'h00;
   logic [7:0] lv = 8'h00;
   logic [5:0] fill = 6'h10;
   logic [7:0] rdata;
   logic [7:0] vec;
   logic irq;
   logic cps;
   logic [2:0] amp;
   int n_errors = 0;
   int checked = 0;
   fim_top u_fim_top (.MCLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .EBIT_CNT_OVF(ovf[0]), .LCRC_CNT_OVF(ovf[1]), .FAS_CNT_OVF(ovf[2]),
      .BITERR_CNT_OVF(ovf[3]), .CMF_CNT_OVF(ovf[4]), .CRC_ALIGN_STATUS(lv[0]),
      .AUX_PATTERN_STATUS(lv[1]), .SIG_MF_SYNC_LOST(lv[2]), .CRC_MF_SYNC_LOST(lv[3]),
      .REMOTE_MF_ALARM(lv[4]), .ONE_SECOND_FLAG(lv[5]), .TIMER_ONE_FLAG(lv[6]),
      .TIMER_TWO_FLAG(lv[7]), .JIT_FIFO_FILL(fill), .IRQ(irq), .IRQ_VECTOR(vec),
      .CUSTOM_PULSE_SELECT(cps), .PULSE_AMPLITUDE_CODE(amp));
   // 250 MHz
   initial
      forever #2 clk = ~clk;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the slot after the strobe
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic clear_all;
      wr_reg(OFS_IRQ_CLEAR_A, 8'hff);
      wr_reg(OFS_IRQ_CLEAR_B, 8'hff);
      settle;
   endtask
   task automatic t_regs;
      rd_chk(OFS_IRQ_EN_CNT_ALIGN, 8'h00);
      rd_chk(OFS_IRQ_EN_SYNC_TMR, 8'h00);
      chk(8'(irq), 8'h00);
      wr_reg(OFS_IRQ_EN_CNT_ALIGN, 8'hff);
      wr_reg(OFS_IRQ_EN_SYNC_TMR, 8'hff);
      wr_reg(OFS_TX_PULSE_CTRL, 8'hfd);
      rd_chk(OFS_IRQ_EN_CNT_ALIGN, 8'hff);
      rd_chk(OFS_IRQ_EN_SYNC_TMR, 8'hde);
      rd_chk(OFS_TX_PULSE_CTRL, 8'h0d);
      chk({4'h0, cps, amp}, 8'h0d);
      rd_chk(5'h03, 8'h00);
      wr_reg(OFS_IRQ_EN_CNT_ALIGN, 8'h00);
      wr_reg(OFS_IRQ_EN_SYNC_TMR, 8'h00);
      $display("register test done");
   endtask
   task automatic fire(input int i);
      @(posedge clk);
      ovf <= 5'h01 << i;
      @(posedge clk);
      ovf <= 5'h00;
      settle;
   endtask
   // each overflow masked, then open, then hidden by its enable
   task automatic t_count;
      logic [7:0] bits [5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};
      for (int i = 0; i < 5; i++)
      begin
         fire(i);
         chk(8'(irq), 8'h00);
         wr_reg(OFS_IRQ_EN_CNT_ALIGN, bits[i]);
         fire(i);
         chk(vec, VEC_COUNTER_OVF);
         chk(8'(irq), 8'h01);
         rd_chk(OFS_IRQ_STATUS_A, bits[i]);
         wr_reg(OFS_IRQ_EN_CNT_ALIGN, 8'h00);
         settle;
         chk(8'(irq), 8'h00);
         clear_all;
      end
      $display("counter test done");
   endtask
   // a level held high is one event; only the alignment flag counts a fall
   task automatic t_levels;
      logic [7:0] wa [8] = '{8'h20, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] wb [8] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02};
      logic [7:0] ev [8] = '{8'h08, 8'h40, 8'h80, 8'h80, 8'h80, 8'h08, 8'h08, 8'h08};
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(OFS_IRQ_EN_CNT_ALIGN, wa[i]);
         wr_reg(OFS_IRQ_EN_SYNC_TMR, wb[i]);
         @(posedge clk);
         lv <= 8'h01 << i;
         settle;
         chk(vec, ev[i]);
         rd_chk(OFS_IRQ_STATUS_A, wa[i]);
         rd_chk(OFS_IRQ_STATUS_B, wb[i]);
         rd_chk(OFS_IRQ_VECTOR, ev[i]);
         clear_all;
         chk(8'(irq), 8'h00);
         @(posedge clk);
         lv <= 8'h00;
         settle;
         chk(vec, i == 0 ? 8'h08 : 8'h00);
         clear_all;
      end
      $display("level test done");
   endtask
   task automatic jit(input logic [5:0] f, input logic [7:0] exp);
      @(posedge clk);
      fill <= f;
      settle;
      chk(vec, exp);
      clear_all;
   endtask
   task automatic t_jitter;
      wr_reg(OFS_IRQ_EN_CNT_ALIGN, 8'h08);
      wr_reg(OFS_IRQ_EN_SYNC_TMR, 8'h00);
      jit(6'd5, 8'h00);
      jit(6'd4, VEC_JITTER);
      rd_chk(OFS_SRC_LEVELS, 8'h20);
      jit(6'd27, 8'h00);
      jit(6'd28, VEC_JITTER);
      $display("jitter test done");
   endtask
   // a mid-run reset drops enables and pending status
   task automatic t_reset;
      wr_reg(OFS_IRQ_EN_CNT_ALIGN, 8'h80);
      fire(0);
      chk(8'(irq), 8'h01);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk(8'(irq), 8'h00);
      rd_chk(OFS_IRQ_EN_CNT_ALIGN, 8'h00);
      rd_chk(OFS_IRQ_STATUS_A, 8'h00);
      $display("reset test done");
   endtask
   // watchdog against a hung run
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      stop_test;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_count;
      t_levels;
      t_jitter;
      t_reset;
      stop_test;
   end
endmodule
